// [mdma_params.svh]
`ifndef MDMA_PARAMS_SVH
`define MDMA_PARAMS_SVH
// Overview of operation
// R01: eight identical channels, each with its own control and status registers.
// R02: each channel moves RAM buffer to peripheral register, or peripheral register to RAM.
// R03: per-channel element size is a 16-bit word or a single byte.
// R04: RAM address comes from a channel register, post-incremented or held fixed.
// R05: peripheral-indirect mode builds the RAM address partly from peripheral-supplied bits.
// R06: one-shot mode stops after one block and does not restart by itself.
// R07: continuous mode reloads the buffer start address after every block and goes on.
// R08: ping-pong mode alternates between two start addresses on successive blocks.
// R09: a block starts from selected peripheral requests or from a software-forced request.
// R10: each channel selects its request source among 32 sources.
// R11: each channel raises its interrupt when a whole block has finished.
// R12: optionally the interrupt comes at half block instead of at block end.
// R13: CPU and channel writing the same RAM location together raises the error trap.
// R14: CPU and channel writing the same peripheral register together raises the error trap.
// R15: the RAM is 2 Kbytes and sits at the top of the data space.
// R16: the RAM has concurrent ports, so CPU and channels never stall each other.
// R17: on a concurrent write to one RAM location the CPU write wins.
// R18: software keeps every buffer a channel moves inside the RAM region.
// R19: data path and registers are 16 bits; RAM is byte-addressable 16-bit words.
// R20: each accepted request moves one element; a per-channel count ends the block.
// R21: for byte moves the lowest address bit picks the byte lane.
`define MDMA_NCH 8
`define MDMA_RAM_WORDS 1024
`define MDMA_OFS_CTRL 5'h00
`define MDMA_OFS_SEL 5'h04
`define MDMA_OFS_STA 5'h08
`define MDMA_OFS_STB 5'h0c
`define MDMA_OFS_PADR 5'h10
`define MDMA_OFS_CNT 5'h14
`define MDMA_OFS_DONE 5'h18
`define MDMA_OFS_CUR 5'h1c
`define MDMA_OFS_ERR 12'h100
`define MDMA_CTRL_EN 0
`define MDMA_CTRL_DIR 1
`define MDMA_CTRL_BYTE 2
`define MDMA_CTRL_INC 3
`define MDMA_CTRL_PIND 4
`define MDMA_CTRL_MODE 5
`define MDMA_CTRL_HALF 7
`define MDMA_CTRL_FORCE 8
`define MDMA_MODE_ONESHOT 2'h0
`define MDMA_MODE_CONT 2'h1
`define MDMA_MODE_PP 2'h2
`define MDMA_ERR_RAM 0
`define MDMA_ERR_PER 1
`define MDMA_CTRL_MASK 16'h00ff
`define MDMA_SEL_MASK 16'h001f
`define MDMA_ADR_MASK 16'h07ff
`define MDMA_RST_REG 16'h0000
`endif

// [mdma_pkg.sv]
`include "mdma_params.svh"
package mdma_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_LATCH, ST_STORE} mdma_state_e;
    typedef logic [`MDMA_NCH-1:0][15:0] mdma_reg_t;
    typedef struct packed {
        mdma_state_e st;
        mdma_reg_t ctrl;
        mdma_reg_t sel;
        mdma_reg_t sta;
        mdma_reg_t stb;
        mdma_reg_t padr;
        mdma_reg_t cnt;
        mdma_reg_t done;
        logic [`MDMA_NCH-1:0][10:0] cur;
        logic [`MDMA_NCH-1:0][7:0] pi;
        logic [`MDMA_NCH-1:0] pp;
        logic [`MDMA_NCH-1:0] pend;
        logic [`MDMA_NCH-1:0] irq;
        logic [2:0] ch;
        logic [10:0] ea;
        logic [15:0] pa;
        logic [15:0] data;
        logic [1:0] err;
        logic [31:0] prdata;
    } mdma_top_s;
endpackage

// [mdma_arb.sv]
`timescale 1ns/100ps
module mdma_arb #(
    parameter int N = 8,
    parameter int IW = 3
) (
    input wire logic [N-1:0] req, // pending channels
    output logic any, // something pending
    output logic [IW-1:0] idx // lowest pending channel
);
    always_comb
    begin
        any = |req;
        idx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = i[IW-1:0];
            end
        end
    end
endmodule

// [mdma_ram.sv]
`timescale 1ns/100ps
module mdma_ram #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic clk, // clock
    input wire logic resetn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic cpu_en, // cpu access
    input wire logic cpu_we, // cpu write
    input wire logic [AW-1:0] cpu_addr, // cpu word index
    input wire logic [1:0] cpu_be, // cpu byte enables
    input wire logic [15:0] cpu_wdata, // cpu write data
    output logic [15:0] cpu_rdata, // cpu read data
    input wire logic dma_re, // channel read
    input wire logic dma_we, // channel write
    input wire logic [AW-1:0] dma_addr, // channel word index
    input wire logic [1:0] dma_be, // channel byte enables
    input wire logic [15:0] dma_wdata, // channel write data
    output logic [15:0] dma_rdata, // channel read data
    output logic collide // write collision seen
);
    typedef struct packed {
        logic [DEPTH-1:0][15:0] mem;
        logic [15:0] crd;
        logic [15:0] drd;
        logic col;
    } mdma_ram_s;
    mdma_ram_s s_ff, nxt_s;
    logic cw;

    assign cw = cpu_en & cpu_we;
    assign cpu_rdata = s_ff.crd;
    assign dma_rdata = s_ff.drd;
    assign collide = s_ff.col;

    always_comb
    begin
        nxt_s = s_ff;
        for (int b = 0; b < 2; b++)
        begin
            if (dma_we && dma_be[b])
            begin
                nxt_s.mem[dma_addr][b*8 +: 8] = dma_wdata[b*8 +: 8];
            end
            if (cw && cpu_be[b])
            begin
                nxt_s.mem[cpu_addr][b*8 +: 8] = cpu_wdata[b*8 +: 8]; // [R17]
            end
        end
        nxt_s.col = cw & dma_we & (cpu_addr == dma_addr) & (|(cpu_be & dma_be)); // [R13]
        if (cpu_en && !cpu_we)
        begin
            nxt_s.crd = s_ff.mem[cpu_addr]; // [R16]
        end
        if (dma_re)
        begin
            nxt_s.drd = s_ff.mem[dma_addr]; // [R16]
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_ff <= '0;
        end
        else if (ce)
        begin
            s_ff <= nxt_s;
        end
    end

    cpu_wins_a: assert property (@(posedge clk) disable iff (!resetn) // [R17]
        ce && cw && dma_we && cpu_addr == dma_addr && cpu_be == 2'h3
        |=> s_ff.mem[$past(cpu_addr)] == $past(cpu_wdata))
        else $error("cpu write lost to channel write");
    ram_collide_c: cover property (@(posedge clk) disable iff (!resetn) ce && nxt_s.col);
endmodule

// [mdma_top.sv]
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "mdma_params.svh"
module mdma_top #(
    parameter logic [15:0] RAM_BASE = 16'hf800 // top 2 Kbytes of the data space
) (
    input wire logic CLK, // clock
    input wire logic RESETN, // async reset, active low
    input wire logic CE, // clock enable
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic CPU_EN, // cpu data access
    input wire logic CPU_WE, // cpu write
    input wire logic [15:0] CPU_EA, // cpu byte address
    input wire logic [1:0] CPU_BE, // cpu byte enables
    input wire logic [15:0] CPU_WDATA, // cpu write data
    output logic [15:0] CPU_RDATA, // cpu read data
    input wire logic CPU_PWE, // cpu peripheral register write
    input wire logic [15:0] CPU_PADDR, // cpu peripheral register address
    input wire logic [31:0] REQ, // peripheral requests
    input wire logic [7:0] PI_OFS, // peripheral address bits
    output logic [15:0] PER_ADDR, // peripheral register address
    output logic [15:0] PER_WDATA, // peripheral write data
    output logic PER_WE, // peripheral write strobe
    output logic PER_RE, // peripheral read strobe
    output logic PER_BYTE, // byte-sized access
    input wire logic [15:0] PER_RDATA, // peripheral read data
    output logic [7:0] CH_IRQ, // per-channel interrupt pulse
    output logic DMA_TRAP // collision error trap
);
    mdma_pkg::mdma_top_s s_ff, nxt_s;
    logic [7:0] newreq;
    logic [7:0] force_wr;
    logic gany;
    logic take;
    logic [2:0] gi;
    logic [2:0] c;
    logic wr;
    logic wr_ch;
    logic [10:0] base_g;
    logic [10:0] ea_raw;
    logic [10:0] ea_calc;
    logic [15:0] dn;
    logic [15:0] cnt_e;
    logic [15:0] hitpt;
    logic blk;
    logic fin;
    logic dirc;
    logic bytec;
    logic [1:0] modec;
    logic cpu_sel;
    logic dma_re;
    logic dma_we;
    logic [1:0] dma_be;
    logic [15:0] dma_rdata;
    logic ram_col;
    logic per_col;
    logic [1:0] err_clr;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[1:0] == 2'h0) && (a[11:8] == 4'h0 || a == `MDMA_OFS_ERR);
    endfunction

    function automatic logic [15:0] lane(input logic [15:0] d, input logic hi, input logic bt);
        lane = !bt ? d : (hi ? {8'h00, d[15:8]} : {8'h00, d[7:0]}); // [R21]
    endfunction

    assign wr = PSEL & PENABLE & PWRITE;
    assign wr_ch = wr & (PADDR[11:8] == 4'h0);
    assign take = (s_ff.st == mdma_pkg::ST_IDLE) & gany;
    assign c = s_ff.ch;
    assign dirc = s_ff.ctrl[c][`MDMA_CTRL_DIR];
    assign bytec = s_ff.ctrl[c][`MDMA_CTRL_BYTE];
    assign modec = s_ff.ctrl[c][`MDMA_CTRL_MODE +: 2];
    assign fin = CE & (s_ff.st == mdma_pkg::ST_STORE);

    generate
        for (genvar g = 0; g < `MDMA_NCH; g++)
        begin : g_req
            assign force_wr[g] = wr_ch & (PADDR[7:5] == g) & (PADDR[4:0] == `MDMA_OFS_CTRL)
                & PWDATA[`MDMA_CTRL_FORCE];
            assign newreq[g] = s_ff.ctrl[g][`MDMA_CTRL_EN]
                & (REQ[s_ff.sel[g][4:0]] | force_wr[g]); // [R09] [R10]
        end
    endgenerate

    mdma_arb #(
        .N(`MDMA_NCH),
        .IW(3)
    ) u_arb (
        .req(s_ff.pend),
        .any(gany),
        .idx(gi)
    );

    // address for the channel about to be served
    always_comb
    begin
        base_g = s_ff.pp[gi] ? s_ff.stb[gi][10:0] : s_ff.sta[gi][10:0]; // [R08]
        if (s_ff.ctrl[gi][`MDMA_CTRL_PIND])
        begin
            ea_raw = base_g + {2'b00, s_ff.pi[gi], 1'b0}; // [R05]
        end
        else
        begin
            ea_raw = s_ff.cur[gi]; // [R04]
        end
        ea_calc = s_ff.ctrl[gi][`MDMA_CTRL_BYTE] ? ea_raw : {ea_raw[10:1], 1'b0}; // [R19]
    end

    assign dn = s_ff.done[c] + 16'h0001;
    assign cnt_e = (s_ff.cnt[c] == 16'h0000) ? 16'h0001 : s_ff.cnt[c];
    assign hitpt = (s_ff.ctrl[c][`MDMA_CTRL_HALF] && cnt_e > 16'h0001) ? {1'b0, cnt_e[15:1]} : cnt_e;
    assign blk = dn >= cnt_e; // [R20]

    assign cpu_sel = CPU_EN & (CPU_EA[15:11] == RAM_BASE[15:11]); // [R15]
    assign dma_re = CE & (s_ff.st == mdma_pkg::ST_MOVE) & dirc;
    assign dma_we = fin & ~dirc;
    assign dma_be = !bytec ? 2'h3 : (s_ff.ea[0] ? 2'h2 : 2'h1); // [R21]

    mdma_ram #(
        .DEPTH(`MDMA_RAM_WORDS),
        .AW(10)
    ) u_ram (
        .clk(CLK),
        .resetn(RESETN),
        .ce(CE),
        .cpu_en(cpu_sel),
        .cpu_we(CPU_WE),
        .cpu_addr(CPU_EA[10:1]),
        .cpu_be(CPU_BE),
        .cpu_wdata(CPU_WDATA),
        .cpu_rdata(CPU_RDATA),
        .dma_re(dma_re),
        .dma_we(dma_we),
        .dma_addr(s_ff.ea[10:1]),
        .dma_be(dma_be),
        .dma_wdata(s_ff.data),
        .dma_rdata(dma_rdata),
        .collide(ram_col)
    );

    assign PER_WE = fin & dirc; // [R02]
    assign PER_RE = CE & (s_ff.st == mdma_pkg::ST_MOVE) & ~dirc; // [R02]
    assign PER_ADDR = s_ff.pa;
    assign PER_WDATA = s_ff.data;
    assign PER_BYTE = bytec; // [R03]
    assign per_col = PER_WE & CPU_PWE & (CPU_PADDR == PER_ADDR); // [R14]
    assign err_clr = (wr && PADDR == `MDMA_OFS_ERR) ? PWDATA[1:0] : 2'h0;

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);
    assign PRDATA = s_ff.prdata;
    assign CH_IRQ = s_ff.irq;
    assign DMA_TRAP = |s_ff.err;

    always_comb
    begin
        logic [2:0] wc;
        logic [15:0] rv;
        wc = PADDR[7:5];
        rv = 16'h0000;
        nxt_s = s_ff;
        nxt_s.irq = '0;
        for (int i = 0; i < `MDMA_NCH; i++)
        begin
            if (newreq[i])
            begin
                nxt_s.pi[i] = PI_OFS; // [R05]
            end
            nxt_s.pend[i] = (s_ff.pend[i] & ~(take & (gi == i[2:0]))) | newreq[i]; // [R20]
        end
        case (s_ff.st)
            mdma_pkg::ST_IDLE:
            begin
                if (gany)
                begin
                    nxt_s.ch = gi;
                    nxt_s.ea = ea_calc;
                    nxt_s.pa = s_ff.padr[gi];
                    nxt_s.st = mdma_pkg::ST_MOVE;
                end
            end
            mdma_pkg::ST_MOVE:
            begin
                if (dirc)
                begin
                    nxt_s.st = mdma_pkg::ST_LATCH;
                end
                else
                begin
                    nxt_s.data = bytec ? {PER_RDATA[7:0], PER_RDATA[7:0]} : PER_RDATA; // [R21]
                    nxt_s.st = mdma_pkg::ST_STORE;
                end
            end
            mdma_pkg::ST_LATCH:
            begin
                nxt_s.data = lane(dma_rdata, s_ff.ea[0], bytec);
                nxt_s.st = mdma_pkg::ST_STORE;
            end
            mdma_pkg::ST_STORE:
            begin
                nxt_s.st = mdma_pkg::ST_IDLE;
                nxt_s.irq[c] = (dn == hitpt); // [R11] [R12]
                if (s_ff.ctrl[c][`MDMA_CTRL_INC] && !s_ff.ctrl[c][`MDMA_CTRL_PIND])
                begin
                    nxt_s.cur[c] = s_ff.cur[c] + (bytec ? 11'h001 : 11'h002); // [R04]
                end
                if (blk)
                begin
                    nxt_s.done[c] = 16'h0000;
                    case (modec)
                        `MDMA_MODE_CONT:
                        begin
                            nxt_s.cur[c] = s_ff.pp[c] ? s_ff.stb[c][10:0] : s_ff.sta[c][10:0]; // [R07]
                        end
                        `MDMA_MODE_PP:
                        begin
                            nxt_s.pp[c] = ~s_ff.pp[c]; // [R08]
                            nxt_s.cur[c] = s_ff.pp[c] ? s_ff.sta[c][10:0] : s_ff.stb[c][10:0]; // [R08]
                        end
                        default:
                        begin
                            nxt_s.ctrl[c][`MDMA_CTRL_EN] = 1'b0; // [R06]
                            nxt_s.cur[c] = s_ff.sta[c][10:0];
                        end
                    endcase
                end
                else
                begin
                    nxt_s.done[c] = dn; // [R20]
                end
            end
            default:
            begin
                nxt_s.st = mdma_pkg::ST_IDLE;
            end
        endcase
        if (wr_ch)
        begin
            case (PADDR[4:0])
                `MDMA_OFS_CTRL:
                begin
                    nxt_s.ctrl[wc] = PWDATA[15:0] & `MDMA_CTRL_MASK; // [R01]
                    if (PWDATA[`MDMA_CTRL_EN] && !s_ff.ctrl[wc][`MDMA_CTRL_EN])
                    begin
                        nxt_s.cur[wc] = s_ff.sta[wc][10:0];
                        nxt_s.done[wc] = 16'h0000;
                        nxt_s.pp[wc] = 1'b0;
                    end
                end
                `MDMA_OFS_SEL:
                begin
                    nxt_s.sel[wc] = PWDATA[15:0] & `MDMA_SEL_MASK; // [R10]
                end
                `MDMA_OFS_STA:
                begin
                    nxt_s.sta[wc] = PWDATA[15:0] & `MDMA_ADR_MASK;
                end
                `MDMA_OFS_STB:
                begin
                    nxt_s.stb[wc] = PWDATA[15:0] & `MDMA_ADR_MASK;
                end
                `MDMA_OFS_PADR:
                begin
                    nxt_s.padr[wc] = PWDATA[15:0];
                end
                `MDMA_OFS_CNT:
                begin
                    nxt_s.cnt[wc] = PWDATA[15:0]; // [R20]
                end
                default:
                begin
                end
            endcase
        end
        nxt_s.err = (s_ff.err & ~err_clr) | {per_col, ram_col}; // [R13] [R14]
        if (PSEL && !PENABLE)
        begin
            if (!mapped(PADDR))
            begin
                rv = 16'h0000;
            end
            else if (PADDR == `MDMA_OFS_ERR)
            begin
                rv = {14'h0000, s_ff.err};
            end
            else
            begin
                case (PADDR[4:0])
                    `MDMA_OFS_CTRL: rv = s_ff.ctrl[wc];
                    `MDMA_OFS_SEL: rv = s_ff.sel[wc];
                    `MDMA_OFS_STA: rv = s_ff.sta[wc];
                    `MDMA_OFS_STB: rv = s_ff.stb[wc];
                    `MDMA_OFS_PADR: rv = s_ff.padr[wc];
                    `MDMA_OFS_CNT: rv = s_ff.cnt[wc];
                    `MDMA_OFS_DONE: rv = s_ff.done[wc];
                    default: rv = {3'h0, s_ff.pp[wc], s_ff.pend[wc], s_ff.cur[wc]};
                endcase
            end
            nxt_s.prdata = {16'h0000, rv};
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s_ff <= '0;
        end
        else if (CE)
        begin
            s_ff <= nxt_s;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    unmapped_err_a: assert property (PSEL && PENABLE && PWRITE && !mapped(PADDR) // [R01]
        |=> s_ff.sel == $past(s_ff.sel) && s_ff.sta == $past(s_ff.sta) && s_ff.cnt == $past(s_ff.cnt))
        else $error("unmapped write changed a register");
    oneshot_stop_a: assert property (fin && blk && modec == `MDMA_MODE_ONESHOT && !PSEL // [R06]
        |=> !s_ff.ctrl[$past(c)][`MDMA_CTRL_EN])
        else $error("one-shot channel still enabled after block");
    cont_reload_a: assert property (fin && blk && modec == `MDMA_MODE_CONT && !PSEL // [R07]
        |=> s_ff.cur[$past(c)] == ($past(s_ff.pp[c]) ? $past(s_ff.stb[c][10:0]) : $past(s_ff.sta[c][10:0])))
        else $error("continuous channel did not reload start address");
    pingpong_swap_a: assert property (fin && blk && modec == `MDMA_MODE_PP && !PSEL // [R08]
        |=> s_ff.pp[$past(c)] != $past(s_ff.pp[c]))
        else $error("ping-pong buffer not swapped");
    block_irq_a: assert property (fin && blk && !s_ff.ctrl[c][`MDMA_CTRL_HALF] && dn == cnt_e // [R11]
        |=> s_ff.irq[$past(c)] ##1 !s_ff.irq[$past(c, 2)])
        else $error("block end interrupt missing");
    half_irq_a: assert property (fin && s_ff.ctrl[c][`MDMA_CTRL_HALF] && cnt_e > 16'h0001 // [R12]
        && dn == {1'b0, cnt_e[15:1]} |=> s_ff.irq[$past(c)])
        else $error("half block interrupt missing");
    ram_trap_a: assert property (CE && ram_col |=> s_ff.err[`MDMA_ERR_RAM] && DMA_TRAP) // [R13]
        else $error("ram collision did not trap");
    per_trap_a: assert property (CE && per_col |=> s_ff.err[`MDMA_ERR_PER] && DMA_TRAP) // [R14]
        else $error("peripheral collision did not trap");
    one_elem_a: assert property (take && CE // [R20]
        |=> s_ff.st == mdma_pkg::ST_MOVE ##[1:2] CE && s_ff.st == mdma_pkg::ST_STORE)
        else $error("element not moved in bounded time");
    byte_lane_a: assert property (dma_we && bytec |-> dma_be == (s_ff.ea[0] ? 2'h2 : 2'h1)) // [R21]
        else $error("byte lane does not follow address bit");

    pingpong_c: cover property (fin && blk && modec == `MDMA_MODE_PP);
    half_irq_c: cover property (fin && s_ff.ctrl[c][`MDMA_CTRL_HALF] && dn == hitpt);
    oneshot_c: cover property (fin && blk && modec == `MDMA_MODE_ONESHOT);
    per_col_c: cover property (CE && per_col);
endmodule

// [mdma_periph_model.sv]
`timescale 1ns/100ps
module mdma_periph_model (
    input wire logic clk, // clock
    input wire logic [15:0] addr, // register address
    input wire logic [15:0] wdata, // write data
    input wire logic we, // write strobe
    input wire logic re, // read strobe
    output logic [15:0] rdata, // read data
    output logic [15:0] last_addr, // last written address
    output logic [15:0] last_data // last written data
);
    logic [7:0] n_rd = 8'h00;
    logic [15:0] held = 16'h0000;
    // outside a read the bus shows the inverse of the last value
    assign rdata = re ? {8'h3c, n_rd} : ~held;
    always @(posedge clk)
    begin
        if (re)
        begin
            n_rd <= n_rd + 8'h01;
            held <= {8'h3c, n_rd};
        end
        if (we)
        begin
            last_addr <= addr;
            last_data <= wdata;
        end
    end
    initial
    begin
        last_addr = 16'h0000;
        last_data = 16'h0000;
    end
endmodule

// [test_multichannel_dma_with_shared_ram.sv]
`timescale 1ns/100ps
`include "mdma_params.svh"
module test_multichannel_dma_with_shared_ram;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic CPU_EN = 1'b0;
    logic CPU_WE = 1'b0;
    logic CPU_PWE = 1'b0;
    logic [15:0] CPU_EA = 16'h0000;
    logic [15:0] CPU_WDATA = 16'h0000;
    logic [15:0] CPU_PADDR = 16'h0000;
    logic [31:0] REQ = 32'h0;
    logic [7:0] PI_OFS = 8'h00;
    logic [31:0] PRDATA, q;
    logic [15:0] CPU_RDATA, PER_ADDR, PER_WDATA, PER_RDATA, m_addr, m_data;
    logic [7:0] CH_IRQ;
    logic PREADY, PSLVERR, PER_WE, PER_RE, PER_BYTE, DMA_TRAP, se;
    int n_by = 0;
    int n_errors = 0;
    int n_tests = 0;
    int n_st = 0;
    int k;
    int irq_n [8] = '{default: 0};
    always #2 CLK = ~CLK;
    mdma_top uut (.CLK, .RESETN, .CE(1'b1), .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .CPU_EN, .CPU_WE, .CPU_EA, .CPU_BE(2'h3), .CPU_WDATA, .CPU_RDATA, .CPU_PWE, .CPU_PADDR,
        .REQ, .PI_OFS, .PER_ADDR, .PER_WDATA, .PER_WE, .PER_RE, .PER_BYTE, .PER_RDATA, .CH_IRQ, .DMA_TRAP);
    mdma_periph_model far (.clk(CLK), .addr(PER_ADDR), .wdata(PER_WDATA), .we(PER_WE), .re(PER_RE),
        .rdata(PER_RDATA), .last_addr(m_addr), .last_data(m_data));
    always @(posedge CLK)
    begin
        n_st <= n_st + int'(PER_RE === 1'b1 || PER_WE === 1'b1);
        n_by <= n_by + int'(PER_WE === 1'b1 && PER_BYTE === 1'b1);
        for (int i = 0; i < 8; i++)
            irq_n[i] <= irq_n[i] + int'(CH_IRQ[i] === 1'b1);
    end
    task automatic chk(string n, logic [31:0] g, logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic logic [11:0] ra(int c, logic [4:0] o);
        return {4'h0, 3'(c), o};
    endfunction
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
            @(posedge CLK);
        while (PREADY !== 1'b1);
        q = PRDATA;
        se = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rg(logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", q, e);
    endtask
    task automatic cfg(int c, logic [15:0] s, logic [15:0] a, logic [15:0] b, logic [15:0] n, logic [15:0] ct);
        apb(1'b1, ra(c, `MDMA_OFS_SEL), {16'h0, s});
        apb(1'b1, ra(c, `MDMA_OFS_STA), {16'h0, a});
        apb(1'b1, ra(c, `MDMA_OFS_STB), {16'h0, b});
        apb(1'b1, ra(c, `MDMA_OFS_CNT), {16'h0, n});
        apb(1'b1, ra(c, `MDMA_OFS_CTRL), {16'h0, ct});
    endtask
    task automatic cpu(logic w, logic [15:0] ea, logic [15:0] d);
        @(posedge CLK);
        CPU_EN <= 1'b1;
        CPU_WE <= w;
        CPU_EA <= ea;
        CPU_WDATA <= d;
        @(posedge CLK);
        CPU_EN <= 1'b0;
        @(posedge CLK);
        q = {16'h0, CPU_RDATA};
    endtask
    task automatic ram(logic [15:0] ea, logic [15:0] e);
        cpu(1'b0, ea, 16'h0000);
        chk("ram", q, {16'h0, e});
    endtask
    // waits for one element strobe, then for store and interrupt
    task automatic wt;
        k = n_st;
        for (int i = 0; i < 20 && n_st == k; i++)
            @(posedge CLK);
        repeat (3) @(posedge CLK);
    endtask
    task automatic rq(int s);
        @(posedge CLK);
        REQ[s] <= 1'b1;
        @(posedge CLK);
        REQ[s] <= 1'b0;
        wt;
    endtask
    initial
    begin
        #40000;
        n_errors++;
        test_done;
    end
    initial
    begin
        repeat (10) @(posedge CLK);
        RESETN <= 1'b1;
        rg(ra(0, `MDMA_OFS_CTRL), 32'h0);
        apb(1'b1, ra(3, `MDMA_OFS_SEL), 32'hffff);
        apb(1'b1, ra(3, 5'h05), 32'h0);
        rg(ra(3, `MDMA_OFS_SEL), 32'h1f);
        rg(ra(2, `MDMA_OFS_SEL), 32'h0);
        chk("unmapped", {31'h0, se}, 32'h0);
        rg(12'h200, 32'h0);
        chk("unmapped", {31'h0, se}, 32'h1);
        cfg(0, 16'h0005, 16'h0010, 16'h0000, 16'h0002, 16'h0009);
        rq(5);
        rq(5);
        chk("irq", irq_n[0], 1);
        rg(ra(0, `MDMA_OFS_CTRL), 32'h8);
        rq(5);
        chk("stopped", n_st, k);
        ram(16'hf810, 16'h3c00);
        ram(16'hf812, 16'h3c01);
        cpu(1'b1, 16'hf840, 16'hbeef);
        apb(1'b1, ra(1, `MDMA_OFS_PADR), 32'h0200);
        cfg(1, 16'h0006, 16'h0041, 16'h0000, 16'h0001, 16'h000f);
        apb(1'b1, ra(1, `MDMA_OFS_CTRL), 32'h010f);
        wt;
        chk("per data", m_data, 16'h00be);
        chk("per addr", m_addr, 16'h0200);
        CPU_PWE <= 1'b1;
        CPU_PADDR <= 16'h0200;
        apb(1'b1, ra(1, `MDMA_OFS_CTRL), 32'h000f);
        apb(1'b1, ra(1, `MDMA_OFS_CTRL), 32'h010f);
        wt;
        CPU_PWE <= 1'b0;
        chk("trap", DMA_TRAP, 1'b1);
        chk("byte", n_by, 2);
        rg(`MDMA_OFS_ERR, 32'h2);
        apb(1'b1, `MDMA_OFS_ERR, 32'h3);
        @(posedge CLK);
        chk("trap", DMA_TRAP, 1'b0);
        cfg(2, 16'h0007, 16'h0080, 16'h0000, 16'h0001, 16'h0029);
        rq(7);
        rq(7);
        ram(16'hf880, 16'h3c03);
        ram(16'hf882, 16'h0000);
        chk("irq", irq_n[2], 2);
        cfg(3, 16'h0008, 16'h00a0, 16'h00c0, 16'h0001, 16'h0049);
        rq(8);
        rq(8);
        ram(16'hf8a0, 16'h3c04);
        ram(16'hf8c0, 16'h3c05);
        cfg(4, 16'h0009, 16'h0100, 16'h0000, 16'h0004, 16'h0089);
        rq(9);
        rq(9);
        chk("irq", irq_n[4], 1);
        rg(ra(4, `MDMA_OFS_DONE), 32'h2);
        rq(9);
        rq(9);
        chk("irq", irq_n[4], 1);
        ram(16'hf906, 16'h3c09);
        cfg(5, 16'h000a, 16'h0120, 16'h0000, 16'h0002, 16'h0001);
        rq(10);
        rq(10);
        ram(16'hf920, 16'h3c0b);
        ram(16'hf922, 16'h0000);
        PI_OFS <= 8'h03;
        cfg(6, 16'h000b, 16'h0140, 16'h0000, 16'h0001, 16'h0011);
        rq(11);
        ram(16'hf946, 16'h3c0c);
        cfg(7, 16'h001f, 16'h01e0, 16'h0000, 16'h0001, 16'h0009);
        CPU_EN <= 1'b1;
        CPU_WE <= 1'b1;
        CPU_EA <= 16'hf9e0;
        CPU_WDATA <= 16'h7777;
        rq(31);
        CPU_EN <= 1'b0;
        CPU_WE <= 1'b0;
        ram(16'hf9e0, 16'h7777);
        chk("trap", DMA_TRAP, 1'b1);
        rg(`MDMA_OFS_ERR, 32'h1);
        cfg(6, 16'h000c, 16'h0161, 16'h0000, 16'h0001, 16'h0005);
        rq(12);
        ram(16'hf960, 16'h0e00);
        cpu(1'b1, 16'h0300, 16'h1234);
        ram(16'hfb00, 16'h0000);
        apb(1'b1, ra(5, `MDMA_OFS_CNT), 32'h0001ffff);
        rg(ra(5, `MDMA_OFS_CNT), 32'hffff);
        test_done;
    end
endmodule
